// >>> rtl/packet_start_indicator.sv
// top: registers, transmit fifo and packet start indications per direction
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps

module packet_start_indicator
(
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	input  wire logic [15:0]          addr_i,
	input  wire logic [15:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic [15:0]               rdata_o,
	input  wire pstart_pkg::mii_nib_s rx_mii_i,
	input  wire pstart_pkg::mii_nib_s tx_mii_i,
	output pstart_pkg::mii_nib_s      tx_mii_o,
	output logic                      tx_ind_o,
	output logic                      rx_ind_o
);

	logic [15:0]            fifo_timing_q;
	logic [15:0]            start_ctrl_q;
	logic [15:0]            rdata_q;
	logic [15:0]            rd_mux;
	logic [15:0]            status;
	pstart_pkg::start_cfg_s tx_cfg;
	pstart_pkg::start_cfg_s rx_cfg;
	pstart_pkg::mii_nib_s   fifo_out;
	logic                   fifo_out_en;
	wire                    hit_timing;
	wire                    hit_ctrl;
	wire                    hit_status;
	wire                    sync_timing;

	// address decode
	assign hit_timing = (addr_i == pstart_pkg::TX_FIFO_TIMING_ADDR);
	assign hit_ctrl   = (addr_i == pstart_pkg::PACKET_START_ADDR);
	assign hit_status = (addr_i == pstart_pkg::START_STATUS_ADDR);

	assign status = {14'h0000, rx_ind_o, tx_ind_o};

	assign rd_mux = hit_timing ? fifo_timing_q :
		hit_ctrl ? start_ctrl_q :
		hit_status ? status : 16'h0000;

	assign sync_timing = fifo_timing_q[pstart_pkg::FIFO_TIMING_BIT];

	// per-direction configuration views of the control register
	assign tx_cfg = {
		start_ctrl_q[pstart_pkg::TX_EN_BIT],
		start_ctrl_q[pstart_pkg::DELIM_BIT],
		start_ctrl_q[pstart_pkg::FIXED_BIT],
		start_ctrl_q[pstart_pkg::CODE_LSB +: pstart_pkg::CODE_W]
	};
	assign rx_cfg = {
		start_ctrl_q[pstart_pkg::RX_EN_BIT],
		start_ctrl_q[pstart_pkg::DELIM_BIT],
		start_ctrl_q[pstart_pkg::FIXED_BIT],
		start_ctrl_q[pstart_pkg::CODE_LSB +: pstart_pkg::CODE_W]
	};

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			fifo_timing_q <= pstart_pkg::TX_FIFO_TIMING_RESET;
			start_ctrl_q  <= pstart_pkg::PACKET_START_RESET;
			rdata_q       <= 16'h0000;
		end
		else
		begin
			if (wr_i && hit_timing)
				fifo_timing_q <= wdata_i & pstart_pkg::TX_FIFO_TIMING_MASK;
			if (wr_i && hit_ctrl)
				start_ctrl_q <= wdata_i & pstart_pkg::PACKET_START_MASK;
			rdata_q <= rd_i ? rd_mux : 16'h0000;
		end
	end

	assign rdata_o = rdata_q;

	// transmit data passes the fifo before detection
	tx_timing_fifo u_tx_fifo
	(
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.sync_i   (sync_timing),
		.nib_i    (tx_mii_i),
		.nib_en_o (fifo_out_en),
		.nib_o    (fifo_out)
	);

	assign tx_mii_o = fifo_out;

	start_detector u_tx_det
	(
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.nib_i   (fifo_out),
		.cfg_i   (tx_cfg),
		.ind_o   (tx_ind_o)
	);

	start_detector u_rx_det
	(
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.nib_i   (rx_mii_i),
		.cfg_i   (rx_cfg),
		.ind_o   (rx_ind_o)
	);

	// helper: cycles each indication has been high
	logic [7:0] rx_hold_q;
	logic [7:0] tx_hold_q;
	logic [7:0] ctrl_len;

	assign ctrl_len = ({5'h00, rx_cfg.code} + 8'h01)
		<< pstart_pkg::HOLD_UNIT_LOG2;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_hold_q <= 8'h00;
			tx_hold_q <= 8'h00;
		end
		else
		begin
			rx_hold_q <= rx_ind_o ? rx_hold_q + 8'h01 : 8'h00;
			tx_hold_q <= tx_ind_o ? tx_hold_q + 8'h01 : 8'h00;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// a drop after an enabled, fixed, live cycle ends a counted hold
	sequence rx_fixed_drop;
		rx_mii_i.en && rx_cfg.enable && rx_cfg.fixed_sel
		##1 $fell(rx_ind_o);
	endsequence

	sequence tx_fixed_drop;
		fifo_out.en && tx_cfg.enable && tx_cfg.fixed_sel
		##1 $fell(tx_ind_o);
	endsequence

	rx_fixed_len_a: assert property (
		rx_fixed_drop |-> rx_hold_q == $past(ctrl_len))
		else $error("rx hold length differs from programmed length");

	tx_fixed_len_a: assert property (
		tx_fixed_drop |-> tx_hold_q == $past(ctrl_len))
		else $error("tx hold length differs from programmed length");

	rx_frame_end_a: assert property (
		!rx_mii_i.en |=> !rx_ind_o)
		else $error("rx indication outlived its frame");

	tx_frame_end_a: assert property (
		!fifo_out.en |=> !tx_ind_o)
		else $error("tx indication outlived its frame");

	whole_frame_a: assert property (
		rx_ind_o && rx_mii_i.en && rx_cfg.enable && !rx_cfg.fixed_sel
		|=> rx_ind_o)
		else $error("rx indication dropped inside frame");

	sfd_start_a: assert property (
		$rose(rx_ind_o) && $past(rx_cfg.delim_sel)
		|-> $past(rx_mii_i.data) == pstart_pkg::SFD_NIBBLE)
		else $error("rx indication rose without delimiter");

	first_nibble_a: assert property (
		$rose(rx_ind_o) && $past(!rx_cfg.delim_sel)
		|-> $past(rx_mii_i.en) && !$past(rx_mii_i.en, 2))
		else $error("rx indication rose away from frame start");

	rx_gate_a: assert property (
		!rx_cfg.enable |=> !rx_ind_o)
		else $error("rx indication while rx disabled");

	tx_gate_a: assert property (
		!tx_cfg.enable |=> !tx_ind_o)
		else $error("tx indication while tx disabled");

	tx_after_fifo_a: assert property (
		$rose(tx_ind_o) |-> $past(fifo_out_en))
		else $error("tx indication not tied to fifo output");

	// fifo latency in both timing modes
	sync_latency_a: assert property (
		sync_timing && $past(sync_timing)
		|-> tx_mii_o == $past(tx_mii_i))
		else $error("synchronous fifo latency is not one cycle");

	prefill_latency_a: assert property (
		!sync_timing && $past(!sync_timing)
		|-> tx_mii_o == $past(tx_mii_i, 2))
		else $error("prefill fifo latency is not two cycles");

	// each detector restarts its own count on a new assertion
	hold_restart_a: assert property (
		$rose(rx_ind_o) |-> u_rx_det.cnt_q == 6'h00)
		else $error("rx hold count not restarted");

	tx_restart_a: assert property (
		$rose(tx_ind_o) |-> u_tx_det.cnt_q == 6'h00)
		else $error("tx hold count not restarted");

	// transmit side mirrors of the receive checks
	tx_whole_a: assert property (
		tx_ind_o && fifo_out.en && tx_cfg.enable && !tx_cfg.fixed_sel
		|=> tx_ind_o)
		else $error("tx indication dropped inside frame");

	tx_sfd_a: assert property (
		$rose(tx_ind_o) && $past(tx_cfg.delim_sel)
		|-> $past(fifo_out.data) == pstart_pkg::SFD_NIBBLE)
		else $error("tx indication rose without delimiter");

	tx_first_a: assert property (
		$rose(tx_ind_o) && $past(!tx_cfg.delim_sel)
		|-> $past(fifo_out.en) && !$past(fifo_out.en, 2))
		else $error("tx indication rose away from frame start");

	// once dropped, an indication stays low for the rest of its frame
	rx_single_a: assert property (
		$fell(rx_ind_o) && $past(rx_mii_i.en) && rx_mii_i.en
		|=> !rx_ind_o)
		else $error("rx indication restarted inside frame");

	tx_single_a: assert property (
		$fell(tx_ind_o) && $past(fifo_out.en) && fifo_out.en
		|=> !tx_ind_o)
		else $error("tx indication restarted inside frame");

	// an indication needs a live frame one cycle earlier
	rx_in_frame_a: assert property (
		rx_ind_o |-> $past(rx_mii_i.en))
		else $error("rx indication outside a frame");

	tx_in_frame_a: assert property (
		tx_ind_o |-> $past(fifo_out.en))
		else $error("tx indication outside a frame");

	// register port: read data stand one cycle after the strobe
	rdata_idle_a: assert property (
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data not zero without a read");

	ctrl_read_a: assert property (
		rd_i && hit_ctrl |=> rdata_o == $past(start_ctrl_q))
		else $error("control register read back wrong");

	timing_read_a: assert property (
		rd_i && hit_timing |=> rdata_o == $past(fifo_timing_q))
		else $error("timing register read back wrong");

	status_read_a: assert property (
		rd_i && hit_status
		|=> rdata_o == {14'h0000, $past(rx_ind_o), $past(tx_ind_o)})
		else $error("status register read back wrong");

	unmapped_read_a: assert property (
		rd_i && !hit_timing && !hit_ctrl && !hit_status
		|=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");

	// writes land next cycle, masked to the writable bits
	ctrl_write_a: assert property (
		wr_i && hit_ctrl
		|=> start_ctrl_q
		== ($past(wdata_i) & pstart_pkg::PACKET_START_MASK))
		else $error("control register write lost");

	timing_write_a: assert property (
		wr_i && hit_timing
		|=> fifo_timing_q
		== ($past(wdata_i) & pstart_pkg::TX_FIFO_TIMING_MASK))
		else $error("timing register write lost");

	ctrl_mask_a: assert property (
		(start_ctrl_q & ~pstart_pkg::PACKET_START_MASK) == 16'h0000)
		else $error("reserved control bits set");

	timing_mask_a: assert property (
		(fifo_timing_q & ~pstart_pkg::TX_FIFO_TIMING_MASK) == 16'h0000)
		else $error("reserved timing bits set");

endmodule : packet_start_indicator

// >>> pkg/pstart_pkg.sv
// package: register map, field layout and carriers of the packet start unit
package pstart_pkg;

	// register offsets on the plain register port
	localparam logic [15:0] TX_FIFO_TIMING_ADDR = 16'h9427;
	localparam logic [15:0] PACKET_START_ADDR   = 16'h9428;
	localparam logic [15:0] START_STATUS_ADDR   = 16'h942F;

	// reset values
	localparam logic [15:0] TX_FIFO_TIMING_RESET = 16'h0000;
	localparam logic [15:0] PACKET_START_RESET   = 16'h0034;

	// writable bits of each register
	localparam logic [15:0] TX_FIFO_TIMING_MASK = 16'h0001;
	localparam logic [15:0] PACKET_START_MASK   = 16'h007F;

	// field positions in tx_fifo_timing_select
	localparam int FIFO_TIMING_BIT = 0;

	// field positions in packet_start_control
	localparam int TX_EN_BIT    = 0;
	localparam int RX_EN_BIT    = 1;
	localparam int DELIM_BIT    = 2;
	localparam int FIXED_BIT    = 3;
	localparam int CODE_LSB     = 4;
	localparam int CODE_W       = 3;

	// field positions in the status register
	localparam int STAT_TX_BIT = 0;
	localparam int STAT_RX_BIT = 1;

	// hold length is (code + 1) times this many clock cycles, as a shift
	localparam int HOLD_UNIT_LOG2 = 3;
	localparam int HOLD_CNT_W     = 6;
	localparam int HOLD_LEN_W     = 7;

	// second nibble of the start frame delimiter on a nibble bus
	localparam logic [3:0] SFD_NIBBLE = 4'hD;

	typedef struct packed
	{
		logic       en;
		logic [3:0] data;
	} mii_nib_s;

	typedef struct packed
	{
		logic                    enable;
		logic                    delim_sel;
		logic                    fixed_sel;
		logic [CODE_W-1:0]       code;
	} start_cfg_s;

endpackage : pstart_pkg

// >>> rtl/tx_timing_fifo.sv
// transmit fifo: two-stage prefill, or one stage in synchronous timing
`timescale 1ns/1ps
module tx_timing_fifo
(
	input  wire logic                clk_i,
	input  wire logic                reset_i,
	input  wire logic                sync_i,
	input  wire pstart_pkg::mii_nib_s nib_i,
	output logic                     nib_en_o,
	output pstart_pkg::mii_nib_s     nib_o
);

	pstart_pkg::mii_nib_s stage_q;
	pstart_pkg::mii_nib_s out_q;
	pstart_pkg::mii_nib_s out_d;

	// synchronous timing skips the prefill stage to cut latency
	assign out_d    = sync_i ? nib_i : stage_q;
	assign nib_o    = out_q;
	assign nib_en_o = out_q.en;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			stage_q <= '0;
			out_q   <= '0;
		end
		else
		begin
			stage_q <= nib_i;
			out_q   <= out_d;
		end
	end

endmodule : tx_timing_fifo

// >>> rtl/start_detector.sv
// one direction of packet start detection with optional fixed hold length
`timescale 1ns/1ps
module start_detector
(
	input  wire logic                   clk_i,
	input  wire logic                   reset_i,
	input  wire pstart_pkg::mii_nib_s   nib_i,
	input  wire pstart_pkg::start_cfg_s cfg_i,
	output logic                        ind_o
);

	typedef enum logic [1:0] {IDLE, HOLD, SPENT} det_state_e;

	det_state_e                            state_q;
	det_state_e                            state_d;
	logic [pstart_pkg::HOLD_CNT_W-1:0]     cnt_q;
	logic [pstart_pkg::HOLD_CNT_W-1:0]     cnt_d;
	logic                                  prev_en_q;
	logic                                  ind_q;
	logic [pstart_pkg::HOLD_LEN_W-1:0]     hold_len;
	wire                                   at_last;
	wire                                   trigger;

	assign hold_len = ({4'h0, cfg_i.code} + 7'h01)
		<< pstart_pkg::HOLD_UNIT_LOG2;
	assign at_last  = ({1'b0, cnt_q} == (hold_len - 7'h01));
	// delimiter nibble, or the first nibble of the frame
	assign trigger  = nib_i.en && (cfg_i.delim_sel ?
		(nib_i.data == pstart_pkg::SFD_NIBBLE) : !prev_en_q);
	assign ind_o    = ind_q;

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			IDLE:
			begin
				if (trigger)
				begin
					// a frame seen while disabled is skipped whole
					state_d = cfg_i.enable ? HOLD : SPENT;
					cnt_d   = '0;
				end
			end
			HOLD:
			begin
				cnt_d = cnt_q + 6'h01;
				if (!nib_i.en)
					state_d = IDLE;
				else if (!cfg_i.enable)
					state_d = SPENT;
				else if (cfg_i.fixed_sel && at_last)
					state_d = SPENT;
			end
			SPENT:
			begin
				if (!nib_i.en)
					state_d = IDLE;
			end
			default:
				state_d = IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q   <= IDLE;
			cnt_q     <= '0;
			prev_en_q <= 1'b0;
			ind_q     <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			prev_en_q <= nib_i.en;
			ind_q     <= (state_d == HOLD);
		end
	end

endmodule : start_detector

// >>> verif/mii_frame_src.sv
// frame source standing in for the mac and the line on one nibble bus
`timescale 1ns/1ps
module mii_frame_src
(
	input  wire logic            clk_i,
	input  wire logic            reset_i,
	input  wire logic            go_i,
	input  wire logic [7:0]      len_i,
	output pstart_pkg::mii_nib_s nib_o
);
	logic [7:0] pos_q;
	logic [7:0] len_q;
	logic       tog_q;
	logic [3:0] nib_data;
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pos_q <= 8'h00;
			len_q <= 8'h00;
			tog_q <= 1'b0;
		end
		else
		begin
			tog_q <= ~tog_q;
			if (go_i)
			begin
				pos_q <= 8'h01;
				len_q <= len_i;
			end
			else if (pos_q != 8'h00 && pos_q < len_q)
				pos_q <= pos_q + 8'h01;
			else
				pos_q <= 8'h00;
		end
	end
	// preamble, delimiter, payload; idle data keeps changing
	assign nib_data = (pos_q == 8'h00) ? {4{tog_q}} :
		(pos_q < 8'h04) ? 4'h5 : (pos_q == 8'h04) ? 4'hD : 4'h3;
	assign nib_o = {(pos_q != 8'h00), nib_data};
endmodule : mii_frame_src

// >>> verif/tb_packet_start_indicator.sv
// self-checking bench of the packet start unit
`timescale 1ns/1ps
module tb_packet_start_indicator;
	logic                 clk_i = 1'b0;
	logic                 reset_i = 1'b1;
	logic [15:0]          addr_i = 16'h0000;
	logic [15:0]          wdata_i = 16'h0000;
	logic                 wr_i = 1'b0;
	logic                 rd_i = 1'b0;
	logic [15:0]          rdata_o;
	logic                 go = 1'b0;
	logic [7:0]           flen = 8'h00;
	pstart_pkg::mii_nib_s rx_mii;
	pstart_pkg::mii_nib_s tx_mii;
	pstart_pkg::mii_nib_s tx_mii_o;
	logic                 tx_ind_o;
	logic                 rx_ind_o;
	int                   miscompares = 0;
	int                   checks = 0;
	int                   cycles = 0;
	int                   fd = 2;

	always #10 clk_i = ~clk_i;

	mii_frame_src rx_src (.clk_i(clk_i), .reset_i(reset_i), .go_i(go),
		.len_i(flen), .nib_o(rx_mii));
	mii_frame_src tx_src (.clk_i(clk_i), .reset_i(reset_i), .go_i(go),
		.len_i(flen), .nib_o(tx_mii));
	packet_start_indicator packet_start_indicator_i (.clk_i(clk_i),
		.reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_mii_i(rx_mii),
		.tx_mii_i(tx_mii), .tx_mii_o(tx_mii_o), .tx_ind_o(tx_ind_o),
		.rx_ind_o(rx_ind_o));

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [15:0] s, e);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk("rdata", rdata_o, e);
		@(negedge clk_i);
		chk("rdata idle", rdata_o, 16'h0000);
	endtask : rd

	// both sources start together; count indication cycles per direction
	task automatic frame(input int len, rr, rc, tr, tc);
		int rf;
		int rn;
		int tf;
		int tn;
		int lf;
		rf = -1;
		tf = -1;
		lf = -1;
		rn = 0;
		tn = 0;
		@(posedge clk_i);
		go <= 1'b1;
		flen <= 8'(len);
		@(posedge clk_i);
		go <= 1'b0;
		for (int k = 0; k <= len + 4; k++)
		begin
			@(negedge clk_i);
			if (rx_ind_o === 1'b1)
				rn++;
			if (rx_ind_o === 1'b1 && rf < 0)
				rf = k;
			if (tx_ind_o === 1'b1)
				tn++;
			if (tx_ind_o === 1'b1 && tf < 0)
				tf = k;
			if (tx_mii_o.en === 1'b1 && lf < 0)
				lf = k;
		end
		chk("rx start", 16'(rf), 16'(rr));
		chk("rx length", 16'(rn), 16'(rc));
		chk("tx start", 16'(tf), 16'(tr));
		chk("tx length", 16'(tn), 16'(tc));
		chk("fifo latency", 16'(lf), 16'(fd));
	endtask : frame

	task automatic t_regs();
		rd(16'h9427, 16'h0000);
		rd(16'h9428, 16'h0034);
		wr(16'h9428, 16'hFFFF);
		rd(16'h9428, 16'h007F);
		wr(16'h9427, 16'hFFFF);
		rd(16'h9427, 16'h0001);
		rd(16'h9426, 16'h0000);
		wr(16'h942F, 16'hFFFF);
		rd(16'h942F, 16'h0000);
		wr(16'h9427, 16'h0000);
		wr(16'h9428, 16'h0034);
	endtask : t_regs

	task automatic t_off();
		frame(20, -1, 0, -1, 0);
	endtask : t_off

	task automatic t_whole();
		wr(16'h9428, 16'h0037);
		frame(20, 4, 17, 6, 17);
	endtask : t_whole

	// status bits follow both indications in mid-frame
	task automatic t_status();
		@(posedge clk_i);
		go <= 1'b1;
		flen <= 8'h14;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (7) @(posedge clk_i);
		rd(16'h942F, 16'h0003);
		repeat (30) @(posedge clk_i);
	endtask : t_status

	task automatic t_first();
		wr(16'h9428, 16'h0034);
		wr(16'h9428, 16'h0030);
		wr(16'h9428, 16'h0033);
		frame(20, 1, 20, 3, 20);
	endtask : t_first

	task automatic t_fixed();
		wr(16'h9428, 16'h0030);
		wr(16'h9428, 16'h0034);
		for (int c = 0; c < 8; c++)
		begin
			wr(16'h9428, 16'(c << 4) | 16'h000F);
			frame(80, 4, (c + 1) * 8, 6, (c + 1) * 8);
		end
		frame(30, 4, 27, 6, 27);
	endtask : t_fixed

	task automatic t_sync();
		wr(16'h9428, 16'h0037);
		wr(16'h9427, 16'h0001);
		fd = 1;
		frame(20, 4, 17, 5, 17);
		wr(16'h9427, 16'h0000);
		fd = 2;
		frame(20, 4, 17, 6, 17);
	endtask : t_sync

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		t_regs();
		t_off();
		t_whole();
		t_status();
		t_first();
		t_fixed();
		t_sync();
		end_of_test();
	end
endmodule : tb_packet_start_indicator
